// ### rtl/pgc_consts.svh
// register indices, field positions and reset values of the pre-driver gate control
// Behaviour
// R1: status byte at index 0xE shows each driver on/off, resets to 0.
// R2: after reset heater is general gate driver, both spark channels ignition.
// R3: one mode bit per channel configuration selects ignition or general gate.
// R4: output is pin OR control bit, or AND when combine bit set.
// R5: open-load check only while off, short check only while on.
// R6: open load sets open-load flag, short sets overcurrent flag.
// R7: open load flagged when drain below threshold with test sink active.
// R8: short flagged when drain above short threshold while output on.
// R9: thresholds are fixed; no register setting changes them.
// R10: clearing sink enable disables test sink and open-load detection.
// R11: shared ignition shunt uses single threshold when one input on.
// R12: both shared ignition inputs on selects twice the single threshold.
// R13: one ignition, one general: shunt protects only the ignition channel.
// R14: both general: only channel a uses shunt, b only drain protection.
// R15: heater uses its own dedicated shunt comparison.
// R16: per-output summary bit set when any fault of that output present.
// R17: one status bit set whenever any pre-driver reports a fault.
// R18: controller polls any-fault bit then reads channel status registers.
// R19: combine bit is configuration bit 2, 0 OR, 1 AND.
// R20: mode bit is configuration bit 7, 0 general gate, 1 ignition.
// R21: sink disabled by configuration bit 4 forces open-load flag to 0.
// R22: status bit 7 is OR of fault flags in bits 0 to 3.
// R23: on/off indicators show resolved command, not the stored control bit.
`ifndef PGC_CONSTS_SVH
`define PGC_CONSTS_SVH

// channel slots
`define PGC_NCH 3
`define PGC_CH_HTR 0
`define PGC_CH_SPA 1
`define PGC_CH_SPB 2

// register indices
`define PGC_IDX_MAIN 4'h0
`define PGC_IDX_CH0 4'h7
`define PGC_IDX_IND 4'he
`define PGC_IDX_ANY 4'hf

// configuration fields
`define PGC_B_MODE 7
`define PGC_B_SINK 4
`define PGC_B_ANDSEL 2
`define PGC_CFG_WMASK 8'hd7

// main control bits
`define PGC_B_ON_HTR 0
`define PGC_B_ON_SPB 1
`define PGC_B_ON_SPA 2

// status fields
`define PGC_B_FAULTS 7
`define PGC_B_OL 3
`define PGC_B_OC 2
`define PGC_B_ANY 0
`define PGC_B_IND_OTHER 3

// reset values
`define PGC_RST_MAIN 8'h00
`define PGC_RST_CFG_HTR 8'h10
`define PGC_RST_CFG_SPK 8'h80
`define PGC_RST_IND 8'h00
`define PGC_ZERO8 8'h00

`endif

// ### rtl/pgc_pkg.sv
// types shared by the pre-driver gate control files
package pgc_pkg;
    // register space selected by the access port
    typedef enum logic {PGC_SPACE_CTRL, PGC_SPACE_STAT} pgc_space_t;
    typedef logic [7:0] pgc_byte_t;
endpackage

// ### rtl/pgc_sense_route.sv
// routing of the shared spark shunt comparison by channel modes
`timescale 1ns/10ps
`default_nettype none
module pgc_sense_route
(
    input wire logic modeA,
    input wire logic modeB,
    input wire logic cmdA,
    input wire logic cmdB,
    input wire logic aboveSingle,
    input wire logic aboveDouble,
    output logic doubleSel,
    output logic tripA,
    output logic tripB
);
    logic trip;

    // thresholds live in the analog comparators; only the level is picked here
    always_comb
    begin
        doubleSel = modeA & modeB & cmdA & cmdB; // [R11] [R12]
        trip = doubleSel ? aboveDouble : aboveSingle; // [R9]
        tripA = trip & (modeA | ~modeB); // [R13] [R14]
        tripB = trip & modeB; // [R13] [R14]
    end
endmodule
`default_nettype wire

// ### rtl/pgc_channel.sv
// one pre-driver: input combine, gate output and fault flags
`timescale 1ns/10ps
`default_nettype none
module pgc_channel
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic inPin,
    input wire logic ctrlBit,
    input wire logic andSel,
    input wire logic sinkEn,
    input wire logic drainLow,
    input wire logic drainHigh,
    input wire logic shuntTrip,
    input wire logic flagClr,
    output logic cmdOn,
    output logic gateOut_reg,
    output logic olFlag_reg,
    output logic ocFlag_reg
);
    logic olSet;
    logic ocSet;

    // pin and control bit resolved into the output command
    always_comb
    begin
        cmdOn = andSel ? (inPin & ctrlBit) : (inPin | ctrlBit); // [R4]
        olSet = ~gateOut_reg & sinkEn & drainLow; // [R5] [R7] [R10]
        ocSet = gateOut_reg & (drainHigh | shuntTrip); // [R5] [R8]
    end

    // gate held off while a short stays latched, so the transistor is protected
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            gateOut_reg <= 1'b0;
        else
            gateOut_reg <= cmdOn & ~ocFlag_reg;
    end

    // open-load flag: set beats read-clear, a disabled sink forces zero
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            olFlag_reg <= 1'b0;
        else if (!sinkEn)
            olFlag_reg <= 1'b0; // [R21]
        else if (olSet)
            olFlag_reg <= 1'b1; // [R6]
        else if (flagClr)
            olFlag_reg <= 1'b0;
    end

    // overcurrent flag, set beats read-clear
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            ocFlag_reg <= 1'b0;
        else if (ocSet)
            ocFlag_reg <= 1'b1; // [R6]
        else if (flagClr)
            ocFlag_reg <= 1'b0;
    end

    // ======================================================
    // checks
    property p_ol_only_off;
        @(posedge sys_clk) disable iff (srst)
        $rose(olFlag_reg) |-> $past(gateOut_reg) == 1'b0;
    endproperty
    a_ol_only_off: assert property (p_ol_only_off) else $error("open load while on"); // [R5]

    property p_oc_only_on;
        @(posedge sys_clk) disable iff (srst)
        $rose(ocFlag_reg) |-> $past(gateOut_reg);
    endproperty
    a_oc_only_on: assert property (p_oc_only_on) else $error("short flag without on"); // [R8]

    property p_ol_forced;
        @(posedge sys_clk) disable iff (srst)
        !sinkEn |=> !olFlag_reg;
    endproperty
    a_ol_forced: assert property (p_ol_forced) else $error("open load with sink off"); // [R21]
endmodule
`default_nettype wire

// ### rtl/pgc_gate_ctrl.sv
// top of the pre-driver gate control: registers, channels, shunt routing
`timescale 1ns/10ps
`default_nettype none
`include "pgc_consts.svh"
module pgc_gate_ctrl
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire pgc_pkg::pgc_space_t regSpace,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData_reg,
    input wire logic heater_in_pin,
    input wire logic spark_in_pin_a,
    input wire logic spark_in_pin_b,
    input wire logic heater_drain_sense_low,
    input wire logic heater_drain_sense_high,
    input wire logic spark_drain_sense_a_low,
    input wire logic spark_drain_sense_a_high,
    input wire logic spark_drain_sense_b_low,
    input wire logic spark_drain_sense_b_high,
    input wire logic sparkShuntAboveSingle,
    input wire logic sparkShuntAboveDouble,
    input wire logic heaterShuntAbove,
    input wire logic [4:0] otherDriversOn,
    output logic heater_gate_out,
    output logic spark_gate_out_a,
    output logic spark_gate_out_b,
    output logic sparkShuntDouble_reg,
    output logic anyFault_reg
);
    // ======================================================
    // storage and channel wiring
    pgc_pkg::pgc_byte_t mainReg;
    pgc_pkg::pgc_byte_t cfgReg [`PGC_NCH];
    pgc_pkg::pgc_byte_t statByte [`PGC_NCH];
    pgc_pkg::pgc_byte_t indReg;
    logic [`PGC_NCH-1:0] inPin;
    logic [`PGC_NCH-1:0] ctrlBit;
    logic [`PGC_NCH-1:0] drainLow;
    logic [`PGC_NCH-1:0] drainHigh;
    logic [`PGC_NCH-1:0] shuntTrip;
    logic [`PGC_NCH-1:0] flagClr;
    logic [`PGC_NCH-1:0] cmdOn;
    logic [`PGC_NCH-1:0] gateOut;
    logic [`PGC_NCH-1:0] olFlag;
    logic [`PGC_NCH-1:0] ocFlag;
    logic [`PGC_NCH-1:0] modeIgn;
    logic ctrlWr;
    logic statRd;
    logic doubleSel;

    assign ctrlWr = regWrEn && (regSpace == pgc_pkg::PGC_SPACE_CTRL);
    assign statRd = regRdEn && (regSpace == pgc_pkg::PGC_SPACE_STAT);

    // pins gathered into channel order: heater, spark a, spark b
    assign inPin = {spark_in_pin_b, spark_in_pin_a, heater_in_pin};
    assign drainLow = {spark_drain_sense_b_low, spark_drain_sense_a_low, heater_drain_sense_low};
    assign drainHigh = {spark_drain_sense_b_high, spark_drain_sense_a_high,
        heater_drain_sense_high};
    assign ctrlBit = {mainReg[`PGC_B_ON_SPB], mainReg[`PGC_B_ON_SPA], mainReg[`PGC_B_ON_HTR]};
    assign heater_gate_out = gateOut[`PGC_CH_HTR];
    assign spark_gate_out_a = gateOut[`PGC_CH_SPA];
    assign spark_gate_out_b = gateOut[`PGC_CH_SPB];

    // ======================================================
    // main on/off control byte
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            mainReg <= `PGC_RST_MAIN;
        else if (ctrlWr && regAddr == `PGC_IDX_MAIN)
            mainReg <= regWrData;
    end

    // ======================================================
    // per-channel configuration, flags and status bytes
    genvar i;
    generate
        for (i = 0; i < `PGC_NCH; i++)
        begin : g_ch
            localparam logic [3:0] CH_ADDR = 4'(`PGC_IDX_CH0 + i);
            localparam pgc_pkg::pgc_byte_t CFG_RST =
                (i == `PGC_CH_HTR) ? `PGC_RST_CFG_HTR : `PGC_RST_CFG_SPK;

            // reserved configuration bits stay zero; thresholds have no field
            always_ff @(posedge sys_clk)
            begin
                if (srst)
                    cfgReg[i] <= CFG_RST; // [R2]
                else if (ctrlWr && regAddr == CH_ADDR)
                    cfgReg[i] <= regWrData & `PGC_CFG_WMASK; // [R9]
            end

            assign modeIgn[i] = cfgReg[i][`PGC_B_MODE]; // [R3] [R20]
            // reading a channel's status clears its latched flags
            assign flagClr[i] = statRd && regAddr == CH_ADDR;

            // summary bit is the OR of the flag field
            always_comb
            begin
                statByte[i] = `PGC_ZERO8;
                statByte[i][`PGC_B_OL] = olFlag[i]; // [R6]
                statByte[i][`PGC_B_OC] = ocFlag[i]; // [R6]
                statByte[i][`PGC_B_FAULTS] = olFlag[i] | ocFlag[i]; // [R16] [R22]
            end

            pgc_channel u_ch
            (
                .sys_clk(sys_clk),
                .srst(srst),
                .inPin(inPin[i]),
                .ctrlBit(ctrlBit[i]),
                .andSel(cfgReg[i][`PGC_B_ANDSEL]), // [R19]
                .sinkEn(cfgReg[i][`PGC_B_SINK]), // [R10]
                .drainLow(drainLow[i]),
                .drainHigh(drainHigh[i]),
                .shuntTrip(shuntTrip[i]),
                .flagClr(flagClr[i]),
                .cmdOn(cmdOn[i]),
                .gateOut_reg(gateOut[i]),
                .olFlag_reg(olFlag[i]),
                .ocFlag_reg(ocFlag[i])
            );
        end
    endgenerate

    // ======================================================
    // shunt comparison routing
    pgc_sense_route u_route
    (
        .modeA(modeIgn[`PGC_CH_SPA]),
        .modeB(modeIgn[`PGC_CH_SPB]),
        .cmdA(cmdOn[`PGC_CH_SPA]),
        .cmdB(cmdOn[`PGC_CH_SPB]),
        .aboveSingle(sparkShuntAboveSingle),
        .aboveDouble(sparkShuntAboveDouble),
        .doubleSel(doubleSel),
        .tripA(shuntTrip[`PGC_CH_SPA]), // [R13] [R14]
        .tripB(shuntTrip[`PGC_CH_SPB])
    );
    // heater never shares the spark shunt
    assign shuntTrip[`PGC_CH_HTR] = heaterShuntAbove; // [R15]

    // threshold select drives the analog comparator level
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            sparkShuntDouble_reg <= 1'b0;
        else
            sparkShuntDouble_reg <= doubleSel; // [R12]
    end

    // ======================================================
    // on/off indicators and any-fault summary
    // indicators follow the resolved command so a pin-driven output shows too
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            indReg <= `PGC_RST_IND; // [R1]
        else
            indReg <= {otherDriversOn, cmdOn[`PGC_CH_SPA], cmdOn[`PGC_CH_SPB],
                cmdOn[`PGC_CH_HTR]}; // [R1] [R23]
    end

    // polled by the controller before reading the channel bytes
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            anyFault_reg <= 1'b0;
        else
            anyFault_reg <= |(olFlag | ocFlag); // [R17] [R18]
    end

    // ======================================================
    // read port, one cycle latency, unmapped indices read zero
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            regRdData_reg <= `PGC_ZERO8;
        else if (regRdEn)
        begin
            regRdData_reg <= `PGC_ZERO8;
            if (regSpace == pgc_pkg::PGC_SPACE_CTRL)
            begin
                if (regAddr == `PGC_IDX_MAIN)
                    regRdData_reg <= mainReg;
                for (int k = 0; k < `PGC_NCH; k++)
                    if (regAddr == 4'(`PGC_IDX_CH0 + k))
                        regRdData_reg <= cfgReg[k];
            end
            else
            begin
                if (regAddr == `PGC_IDX_IND)
                    regRdData_reg <= indReg; // [R1]
                if (regAddr == `PGC_IDX_ANY)
                    regRdData_reg <= {7'h00, anyFault_reg}; // [R17]
                for (int k = 0; k < `PGC_NCH; k++)
                    if (regAddr == 4'(`PGC_IDX_CH0 + k))
                        regRdData_reg <= statByte[k]; // [R22]
            end
        end
    end

    // ======================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    property p_reset_modes;
        $past(srst) |-> modeIgn[`PGC_CH_SPA] && modeIgn[`PGC_CH_SPB]
            && !modeIgn[`PGC_CH_HTR] && indReg == `PGC_RST_IND;
    endproperty
    a_reset_modes: assert property (p_reset_modes) else $error("bad reset modes"); // [R2]

    property p_and_blocks;
        cfgReg[`PGC_CH_SPA][`PGC_B_ANDSEL] && !ctrlBit[`PGC_CH_SPA] |-> !cmdOn[`PGC_CH_SPA];
    endproperty
    a_and_blocks: assert property (p_and_blocks) else $error("and select ignored"); // [R4]

    property p_or_pass;
        !cfgReg[`PGC_CH_HTR][`PGC_B_ANDSEL] && heater_in_pin && !ocFlag[`PGC_CH_HTR]
            |=> heater_gate_out;
    endproperty
    a_or_pass: assert property (p_or_pass) else $error("or select lost pin"); // [R4]

    property p_ind_follows;
        ##1 indReg[`PGC_B_ON_SPA] == $past(cmdOn[`PGC_CH_SPA])
            && indReg[`PGC_B_ON_HTR] == $past(cmdOn[`PGC_CH_HTR]);
    endproperty
    a_ind_follows: assert property (p_ind_follows) else $error("indicator stale"); // [R23]

    property p_double_sel;
        spark_in_pin_a && spark_in_pin_b && modeIgn[`PGC_CH_SPA] && modeIgn[`PGC_CH_SPB]
            && !cfgReg[`PGC_CH_SPA][`PGC_B_ANDSEL] && !cfgReg[`PGC_CH_SPB][`PGC_B_ANDSEL]
            |=> sparkShuntDouble_reg;
    endproperty
    a_double_sel: assert property (p_double_sel) else $error("double level missed"); // [R12]

    property p_single_sel;
        (cmdOn[`PGC_CH_SPA] ^ cmdOn[`PGC_CH_SPB]) |=> !sparkShuntDouble_reg;
    endproperty
    a_single_sel: assert property (p_single_sel) else $error("single level missed"); // [R11]

    property p_general_gate_mode_b_unshunted;
        !modeIgn[`PGC_CH_SPB] |-> !shuntTrip[`PGC_CH_SPB];
    endproperty
    a_general_gate_mode_b_unshunted: assert property (p_general_gate_mode_b_unshunted) else $error("b on shunt"); // [R14]

    property p_any_fault;
        ##1 anyFault_reg == $past(|(olFlag | ocFlag));
    endproperty
    a_any_fault: assert property (p_any_fault) else $error("any-fault wrong"); // [R17]

    property p_summary_read;
        statRd && regAddr == `PGC_IDX_CH0 |=> regRdData_reg[`PGC_B_FAULTS]
            == (regRdData_reg[`PGC_B_OL] | regRdData_reg[`PGC_B_OC]);
    endproperty
    a_summary_read: assert property (p_summary_read) else $error("summary bit wrong"); // [R22]

    // shunt routing per mode pair, fault paths and shutdown
    property p_general_gate_mode_a_shunted;
        !modeIgn[`PGC_CH_SPA] && !modeIgn[`PGC_CH_SPB]
            |-> shuntTrip[`PGC_CH_SPA] == sparkShuntAboveSingle;
    endproperty
    a_general_gate_mode_a_shunted: assert property (p_general_gate_mode_a_shunted) else $error("a lost shunt"); // [R14]

    property p_ign_b_only;
        modeIgn[`PGC_CH_SPB] && !modeIgn[`PGC_CH_SPA] |-> !shuntTrip[`PGC_CH_SPA];
    endproperty
    a_ign_b_only: assert property (p_ign_b_only) else $error("general a on shunt"); // [R13]

    property p_heater_shunt;
        heaterShuntAbove && heater_gate_out |=> ocFlag[`PGC_CH_HTR];
    endproperty
    a_heater_shunt: assert property (p_heater_shunt) else $error("heater shunt missed"); // [R15]

    property p_ol_heater;
        cfgReg[`PGC_CH_HTR][`PGC_B_SINK] && !heater_gate_out && heater_drain_sense_low
            |=> olFlag[`PGC_CH_HTR];
    endproperty
    a_ol_heater: assert property (p_ol_heater) else $error("open load missed"); // [R7]

    property p_oc_drain_b;
        spark_gate_out_b && spark_drain_sense_b_high |=> ocFlag[`PGC_CH_SPB];
    endproperty
    a_oc_drain_b: assert property (p_oc_drain_b) else $error("drain short missed"); // [R8]

    property p_oc_shuts_a;
        ocFlag[`PGC_CH_SPA] |=> !spark_gate_out_a;
    endproperty
    a_oc_shuts_a: assert property (p_oc_shuts_a) else $error("gate on while short"); // [R8]

    // main scenarios: double level, open load, short then read-clear, general-mode trip
    c_double: cover property (sparkShuntDouble_reg ##1 !sparkShuntDouble_reg);
    c_open_load: cover property ($rose(olFlag[`PGC_CH_HTR]));
    c_short: cover property ($rose(ocFlag[`PGC_CH_SPA]) ##[1:4] flagClr[`PGC_CH_SPA]);
    c_general_gate_mode_trip: cover property (!modeIgn[`PGC_CH_SPA] && shuntTrip[`PGC_CH_SPA]);
endmodule
`default_nettype wire

// ### sim/pgc_mcu_model.sv
// controller-side model: register master, parallel input pins, fault polling
`timescale 1ns/10ps
`default_nettype none
module pgc_mcu_model
(
    input wire logic sys_clk,
    output var pgc_pkg::pgc_space_t regSpace,
    output logic [3:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrEn,
    output logic regRdEn,
    output logic [2:0] pins
);
    // expected read data, taken off by the bench watcher one cycle after each read
    pgc_pkg::pgc_byte_t expQ[$];
    string nameQ[$];

    // ========================================
    // idle levels
    // pins are {spark a, spark b, heater}; the model drives a released pin low
    initial
    begin
        regSpace = pgc_pkg::PGC_SPACE_CTRL;
        regAddr = 4'h0;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        pins = 3'h0;
    end

    // ========================================
    // register port tasks
    // request held from just after one edge up to the taking edge, then released
    task automatic wr(input pgc_pkg::pgc_space_t sp, input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regSpace <= sp;
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge sys_clk);
        regWrEn <= 1'b0;
        regWrData <= ~d; // released data must not look like the last value
    endtask

    task automatic rd(input pgc_pkg::pgc_space_t sp, input logic [3:0] a, input logic [7:0] e);
        expQ.push_back(e);
        nameQ.push_back($sformatf("read %s %h", sp.name(), a));
        @(posedge sys_clk);
        regSpace <= sp;
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge sys_clk);
        regRdEn <= 1'b0;
    endtask

    // pins change just after an edge, like the register strobes
    task automatic setPins(input logic [2:0] p);
        @(posedge sys_clk);
        pins <= p;
    endtask

    // summary bit first, then each channel's status; each read also clears its flags
    task automatic poll(input logic [7:0] eH, input logic [7:0] eA, input logic [7:0] eB);
        rd(pgc_pkg::PGC_SPACE_STAT, 4'hf, {7'h00, |{eH, eA, eB}});
        rd(pgc_pkg::PGC_SPACE_STAT, 4'h7, eH);
        rd(pgc_pkg::PGC_SPACE_STAT, 4'h8, eA);
        rd(pgc_pkg::PGC_SPACE_STAT, 4'h9, eB);
    endtask
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the pre-driver gate control
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    typedef struct packed
    {
        logic [7:0] cA;
        logic [7:0] cB;
        logic [2:0] pins;
        logic [8:0] sense;
        logic [7:0] eH;
        logic [7:0] eA;
        logic [7:0] eB;
    } pgc_case_t;

    // fault cases; sense is {heater shunt, shunt double, shunt single,
    // drain high h/a/b, drain low h/a/b}, pins are {a, b, heater}
    localparam pgc_case_t caseTbl [17] = '{
        '{8'h80, 8'h80, 3'h0, 9'h004, 8'h88, 8'h00, 8'h00},
        '{8'h80, 8'h80, 3'h1, 9'h004, 8'h00, 8'h00, 8'h00},
        '{8'h80, 8'h80, 3'h0, 9'h020, 8'h00, 8'h00, 8'h00},
        '{8'h80, 8'h80, 3'h1, 9'h020, 8'h84, 8'h00, 8'h00},
        '{8'h80, 8'h80, 3'h0, 9'h002, 8'h00, 8'h00, 8'h00},
        '{8'h90, 8'h80, 3'h0, 9'h002, 8'h00, 8'h88, 8'h00},
        '{8'h80, 8'h80, 3'h4, 9'h040, 8'h00, 8'h84, 8'h00},
        '{8'h80, 8'h80, 3'h6, 9'h040, 8'h00, 8'h00, 8'h00},
        '{8'h80, 8'h80, 3'h6, 9'h0c0, 8'h00, 8'h84, 8'h84},
        '{8'h80, 8'h00, 3'h2, 9'h040, 8'h00, 8'h00, 8'h00},
        '{8'h80, 8'h00, 3'h4, 9'h040, 8'h00, 8'h84, 8'h00},
        '{8'h00, 8'h80, 3'h4, 9'h040, 8'h00, 8'h00, 8'h00},
        '{8'h00, 8'h00, 3'h4, 9'h040, 8'h00, 8'h84, 8'h00},
        '{8'h00, 8'h00, 3'h2, 9'h040, 8'h00, 8'h00, 8'h00},
        '{8'h00, 8'h00, 3'h2, 9'h008, 8'h00, 8'h00, 8'h84},
        '{8'h80, 8'h80, 3'h1, 9'h100, 8'h84, 8'h00, 8'h00},
        '{8'h80, 8'h80, 3'h5, 9'h040, 8'h00, 8'h84, 8'h00}
    };
    localparam pgc_pkg::pgc_space_t spCtrl = pgc_pkg::PGC_SPACE_CTRL;
    localparam pgc_pkg::pgc_space_t spStat = pgc_pkg::PGC_SPACE_STAT;

    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [8:0] sense = 9'h000;
    logic [4:0] otherOn = 5'h00;
    logic rdSeen = 1'b0;
    logic [31:0] rndState = 32'h000063de;
    logic [7:0] cfg;
    logic [7:0] d;
    logic e;
    int pos;
    int fail_count = 0;
    int checks_done = 0;
    pgc_case_t c;
    wire pgc_pkg::pgc_space_t regSpace;
    wire [3:0] regAddr;
    wire [7:0] regWrData;
    wire [7:0] regRdData_reg;
    wire regWrEn;
    wire regRdEn;
    wire [2:0] pins;
    wire [2:0] gates;
    wire dbl;
    wire anyF;

    pgc_mcu_model i_mcu (.sys_clk(sys_clk), .regSpace(regSpace), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .pins(pins));

    pgc_gate_ctrl i_dut (.sys_clk(sys_clk), .srst(srst), .regSpace(regSpace),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData_reg(regRdData_reg), .heater_in_pin(pins[0]), .spark_in_pin_a(pins[2]),
        .spark_in_pin_b(pins[1]), .heater_drain_sense_low(sense[2]),
        .heater_drain_sense_high(sense[5]), .spark_drain_sense_a_low(sense[1]),
        .spark_drain_sense_a_high(sense[4]), .spark_drain_sense_b_low(sense[0]),
        .spark_drain_sense_b_high(sense[3]), .sparkShuntAboveSingle(sense[6]),
        .sparkShuntAboveDouble(sense[7]), .heaterShuntAbove(sense[8]),
        .otherDriversOn(otherOn), .heater_gate_out(gates[0]), .spark_gate_out_a(gates[2]),
        .spark_gate_out_b(gates[1]), .sparkShuntDouble_reg(dbl), .anyFault_reg(anyF));

    // ========================================
    // clock, reporting and random source
    always #2 sys_clk = ~sys_clk;

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic cmpReg(input string n, input logic [7:0] ex, input logic [7:0] g);
        checks_done++;
        if (g !== ex)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, ex, g);
        end
    endtask

    task automatic cmpPin(input string n, input logic [2:0] ex, input logic [2:0] g);
        checks_done++;
        if (g !== ex)
        begin
            fail_count++;
            $display("[FAIL] %s expected %b seen %b", n, ex, g);
        end
    endtask

    function automatic logic [31:0] nextRnd();
        rndState ^= rndState << 13;
        rndState ^= rndState >> 17;
        rndState ^= rndState << 5;
        return rndState;
    endfunction

    // read watcher: data stands from the taking edge on, so look at the edge after it
    always @(posedge sys_clk)
    begin
        if (rdSeen && i_mcu.expQ.size() > 0)
            cmpReg(i_mcu.nameQ.pop_front(), i_mcu.expQ.pop_front(), regRdData_reg);
        rdSeen <= regRdEn;
    end

    // watchdog: a hang is counted as a mismatch
    initial
    begin
        repeat (60000) @(posedge sys_clk);
        fail_count++;
        tally_and_finish();
    end

    // ========================================
    // main sequence
    initial
    begin
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        // reset values, unmapped and refused accesses
        i_mcu.rd(spCtrl, 4'h0, 8'h00);
        i_mcu.rd(spCtrl, 4'h7, 8'h10);
        i_mcu.rd(spCtrl, 4'h8, 8'h80);
        i_mcu.rd(spCtrl, 4'h9, 8'h80);
        i_mcu.rd(spStat, 4'he, 8'h00);
        i_mcu.rd(spStat, 4'h8, 8'h00);
        i_mcu.rd(spStat, 4'hf, 8'h00);
        i_mcu.rd(spCtrl, 4'h5, 8'h00);
        i_mcu.wr(spStat, 4'he, 8'hff);
        i_mcu.rd(spStat, 4'he, 8'h00);
        // every pin, control bit and combine choice on every channel
        for (int ch = 0; ch < 3; ch++)
        begin
            for (int v = 0; v < 8; v++)
            begin
                pos = (ch == 0) ? 0 : 3 - ch;
                cfg = (ch == 0) ? 8'h10 : 8'h80;
                cfg[2] = v[2];
                e = v[2] ? (v[1] & v[0]) : (v[1] | v[0]);
                i_mcu.wr(spCtrl, 4'(7 + ch), cfg);
                i_mcu.wr(spCtrl, 4'h0, 8'(v[0]) << pos);
                otherOn <= 5'(nextRnd());
                i_mcu.setPins(3'(v[1]) << pos);
                repeat (3) @(posedge sys_clk);
                cmpPin("gates", 3'(e) << pos, gates);
                i_mcu.rd(spStat, 4'he, {otherOn, 3'(e) << pos});
            end
        end
        i_mcu.wr(spCtrl, 4'h0, 8'h00);
        i_mcu.setPins(3'h0);
        // random configuration bytes; the unused bits 5 and 3 read back as 0
        for (int r = 7; r < 10; r++)
        begin
            d = 8'(nextRnd());
            i_mcu.wr(spCtrl, 4'(r), d);
            i_mcu.rd(spCtrl, 4'(r), d & 8'hd7);
        end
        i_mcu.wr(spCtrl, 4'h7, 8'h10);
        // fault detection, shunt routing, shutdown and polling
        foreach (caseTbl[i])
        begin
            c = caseTbl[i];
            i_mcu.wr(spCtrl, 4'h8, c.cA);
            i_mcu.wr(spCtrl, 4'h9, c.cB);
            i_mcu.setPins(c.pins);
            repeat (3) @(posedge sys_clk);
            cmpPin("shunt double", 3'(c.cA[7] & c.cB[7] & c.pins[2] & c.pins[1]), 3'(dbl));
            sense <= c.sense;
            repeat (2) @(posedge sys_clk);
            sense <= 9'h000;
            repeat (2) @(posedge sys_clk);
            cmpPin("gates", c.pins & ~{c.eA[2], c.eB[2], c.eH[2]}, gates);
            cmpPin("any fault", 3'(|{c.eH, c.eA, c.eB}), 3'(anyF));
            i_mcu.setPins(3'h0);
            repeat (2) @(posedge sys_clk);
            i_mcu.poll(c.eH, c.eA, c.eB);
        end
        // let the last reads come back, under a bound
        for (int k = 0; k < 8 && i_mcu.expQ.size() != 0; k++)
            @(posedge sys_clk);
        if (i_mcu.expQ.size() != 0)
            fail_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
